//--- nand_feature_protect_die_ctrl.v
// Host controller driving a parallel NAND for features, protection, dies
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.vh"
module nand_feature_protect_die_ctrl (
  // Clock, reset and enable
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // NAND pins
  output reg nandCeN,
  output reg nandCle,
  output reg nandAle,
  output reg nandWeN,
  output reg nandReN,
  output reg nandWpN,
  output reg [7:0] nandIoOut,
  output reg nandIoOe,
  input wire [7:0] nandIoIn,
  input wire nandRbN
);
  // States
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETUP = 3'd1;
  localparam [2:0] ST_LOW = 3'd2;
  localparam [2:0] ST_HIGH = 3'd3;
  localparam [2:0] ST_WAIT = 3'd4;
  localparam [2:0] ST_DONE = 3'd5;
  // Byte kinds in a sequence
  localparam [1:0] K_CMD = 2'd0;
  localparam [1:0] K_ADR = 2'd1;
  localparam [1:0] K_DAT = 2'd2;
  localparam [1:0] K_RD = 2'd3;

  reg [2:0] state_q;
  reg [3:0] op_q;
  reg [3:0] step_q;
  reg [31:0] arg0_q;
  reg [31:0] arg1_q;
  reg [31:0] featRd_q;
  reg [7:0] dieStat_q;
  reg busy_q;
  reg errOrder_q;
  reg errSeq_q;
  reg protFail_q;
  reg lastInfo_q;
  reg wpN_q;
  reg [7:0] featDrive_q;
  reg apWrite_q;
  reg apValid_q;
  reg [7:0] apAddr_q;
  reg tLoad;
  reg [7:0] tCount;
  wire tDone;
  wire inOrder;
  reg commitProg;
  reg eraseDone;

  // Sequence length of each operation
  function [3:0] seqLen;
    input [3:0] op;
    begin
      case (op)
        `OP_SETFEAT: seqLen = 4'd6;
        `OP_GETFEAT: seqLen = 4'd6;
        `OP_PROTECT: seqLen = 4'd9;
        `OP_DIESTAT: seqLen = 4'd5;
        `OP_RESET: seqLen = 4'd1;
        `OP_PROGRAM: seqLen = 4'd7;
        `OP_ERASE: seqLen = 4'd5;
        default: seqLen = 4'd0;
      endcase
    end
  endfunction

  // Kind of byte at a step
  function [1:0] byteKind;
    input [3:0] op;
    input [3:0] step;
    begin
      case (op)
        `OP_SETFEAT: byteKind = (step == 4'd0) ? K_CMD :
                               (step == 4'd1) ? K_ADR : K_DAT;
        `OP_GETFEAT: byteKind = (step == 4'd0) ? K_CMD :
                               (step == 4'd1) ? K_ADR : K_RD;
        `OP_PROTECT: byteKind = (step < 4'd4) ? K_CMD : K_ADR;
        `OP_DIESTAT: byteKind = (step == 4'd0) ? K_CMD :
                               (step == 4'd4) ? K_RD : K_ADR;
        `OP_PROGRAM: byteKind = (step == 4'd0 || step == 4'd6) ?
                               K_CMD : K_ADR;
        `OP_ERASE: byteKind = (step == 4'd0 || step == 4'd4) ?
                             K_CMD : K_ADR;
        default: byteKind = K_CMD;
      endcase
    end
  endfunction

  // Byte value at a step; arg0 carries addresses, arg1 extras
  function [7:0] byteVal;
    input [3:0] op;
    input [3:0] step;
    input [31:0] a0;
    input [31:0] a1;
    input [7:0] drv;
    begin
      byteVal = 8'h00;
      case (op)
        `OP_SETFEAT: begin
          if (step == 4'd0) byteVal = `CMD_SETFEAT;
          else if (step == 4'd1) byteVal = a0[7:0];
          else if (step == 4'd2) byteVal = drv;
        end
        `OP_GETFEAT: begin
          if (step == 4'd0) byteVal = `CMD_GETFEAT;
          else if (step == 4'd1) byteVal = a0[7:0];
        end
        `OP_PROTECT: begin
          case (step)
            4'd0: byteVal = `CMD_PROT0;
            4'd1: byteVal = `CMD_PROT1;
            4'd2: byteVal = `CMD_PROT2;
            4'd3: byteVal = `CMD_PROT3;
            4'd4: byteVal = a0[15:8];
            4'd5: byteVal = a0[7:0];
            4'd6: byteVal = a1[15:8];
            4'd7: byteVal = a1[7:0];
            4'd8: byteVal = a1[23:16];
            default: byteVal = 8'h00;
          endcase
        end
        // 78h then page, block, die rows
        `OP_DIESTAT: begin
          if (step == 4'd0) byteVal = `CMD_DIESTAT;
          else if (step == 4'd1) byteVal = a0[7:0];
          else if (step == 4'd2) byteVal = a0[15:8];
          else if (step == 4'd3) byteVal = a0[23:16];
        end
        `OP_RESET: byteVal = `CMD_RESET;
        `OP_PROGRAM: begin
          case (step)
            4'd0: byteVal = `CMD_PROG0;
            4'd1: byteVal = 8'h00;
            4'd2: byteVal = 8'h00;
            4'd3: byteVal = a0[7:0];
            4'd4: byteVal = a0[15:8];
            4'd5: byteVal = a0[23:16];
            default: byteVal = `CMD_PROG1;
          endcase
        end
        `OP_ERASE: begin
          case (step)
            4'd0: byteVal = `CMD_ERASE0;
            4'd1: byteVal = a0[7:0];
            4'd2: byteVal = a0[15:8];
            4'd3: byteVal = a0[23:16];
            default: byteVal = `CMD_ERASE1;
          endcase
        end
        default: byteVal = 8'h00;
      endcase
    end
  endfunction

  wire [1:0] kindNow = byteKind(op_q, step_q);
  wire lastStep = (step_q == seqLen(op_q) - 4'd1);
  // Array ops and feature writes wait on ready/busy after the last byte;
  // a feature read waits after its address, before any byte is fetched
  wire waitsBusy = lastStep ?
                   ((op_q == `OP_RESET) || (op_q == `OP_PROGRAM) ||
                    (op_q == `OP_ERASE) || (op_q == `OP_SETFEAT)) :
                   ((op_q == `OP_GETFEAT) && (step_q == 4'd1));
  // Phase lengths, cut on purpose to the timer's eight bits
  localparam [31:0] STROBE_CNT = `STROBE_CYC;
  localparam [31:0] FEAT_CNT = `FEAT_CYC;
  wire featReserved = (arg0_q[7:0] != `FEAT_DRIVE_ADDR);
  // Block address bits 21:6 of the row word; page in bits 5:0
  wire [15:0] blkAddr = arg0_q[21:6];
  wire [5:0] pgAddr = arg0_q[5:0];

  strobe_timer u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .load(tLoad),
    .count(tCount),
    .done(tDone)
  );

  page_order_check u_order (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .blockAddr(blkAddr),
    .pageAddr(pgAddr),
    .commit(commitProg),
    .eraseDone(eraseDone),
    .inOrder(inOrder)
  );

  // Timer load for each phase
  always @* begin
    tLoad = 1'b0;
    tCount = 8'h00;
    commitProg = 1'b0;
    eraseDone = 1'b0;
    if (clkEn) begin
      if (state_q == ST_SETUP || state_q == ST_LOW ||
          (state_q == ST_HIGH && tDone && waitsBusy)) begin
        if (tDone || state_q == ST_SETUP) begin
          tLoad = 1'b1;
          tCount = (state_q == ST_HIGH) ? FEAT_CNT[7:0] : STROBE_CNT[7:0];
        end
      end
      if (state_q == ST_HIGH && tDone && lastStep) begin
        commitProg = (op_q == `OP_PROGRAM);
        eraseDone = (op_q == `OP_ERASE);
      end
    end
  end

  // AHB address phase capture and single-cycle answers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      apValid_q <= 1'b0;
      apWrite_q <= 1'b0;
      apAddr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      apValid_q <= hsel && htrans[1] && hready;
      apWrite_q <= hwrite;
      apAddr_q <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr)
          `REG_CTRL: hrdata <= {23'h0, wpN_q, op_q, 3'h0, busy_q};
          `REG_ARG0: hrdata <= arg0_q;
          `REG_ARG1: hrdata <= arg1_q;
          `REG_STAT: hrdata <= {26'h0, lastInfo_q, protFail_q, errSeq_q,
                                errOrder_q, nandRbN, busy_q};
          `REG_FEAT: hrdata <= featRd_q;
          `REG_DSTAT: hrdata <= {24'h0, dieStat_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Main sequencer and register writes
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      op_q <= 4'h0;
      step_q <= 4'h0;
      arg0_q <= 32'h00000000;
      arg1_q <= 32'h00000000;
      featRd_q <= 32'h00000000;
      dieStat_q <= 8'h00;
      busy_q <= 1'b0;
      errOrder_q <= 1'b0;
      errSeq_q <= 1'b0;
      protFail_q <= 1'b0;
      lastInfo_q <= 1'b0;
      // write protect held low from reset
      wpN_q <= 1'b0;
      featDrive_q <= `FEAT_DRIVE_RST;
      nandCeN <= 1'b1;
      nandCle <= 1'b0;
      nandAle <= 1'b0;
      nandWeN <= 1'b1;
      nandReN <= 1'b1;
      nandWpN <= 1'b0;
      nandIoOut <= 8'h00;
      nandIoOe <= 1'b0;
    end else if (clkEn) begin
      nandWpN <= wpN_q;
      if (apValid_q && apWrite_q) begin
        case (apAddr_q)
          `REG_ARG0: if (!busy_q) arg0_q <= hwdata;
          `REG_ARG1: begin
            if (!busy_q) arg1_q <= hwdata;
            if (!busy_q) featDrive_q <= hwdata[7:0];
          end
          `REG_CTRL: begin
            wpN_q <= hwdata[`CTRL_WP_BIT];
            // one sequence at a time, GO refused while busy
            if (hwdata[`CTRL_GO_BIT] && !busy_q) begin
              op_q <= hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
              step_q <= 4'h0;
              busy_q <= 1'b1;
              errSeq_q <= 1'b0;
              errOrder_q <= 1'b0;
              protFail_q <= 1'b0;
              state_q <= ST_SETUP;
            end
          end
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          nandCeN <= 1'b1;
          nandIoOe <= 1'b0;
        end
        ST_SETUP: begin
          // die work refused right after info commands
          // reserved feature address skipped, reads give zero
          // all but die status wait for shared ready first
          if (seqLen(op_q) == 4'd0 ||
              ((op_q == `OP_PROGRAM || op_q == `OP_ERASE) && lastInfo_q)) begin
            errSeq_q <= 1'b1;
            state_q <= ST_DONE;
          end else if (op_q == `OP_PROGRAM && !inOrder) begin
            errOrder_q <= 1'b1;
            state_q <= ST_DONE;
          end else if ((op_q == `OP_SETFEAT || op_q == `OP_GETFEAT) &&
                       featReserved) begin
            if (op_q == `OP_GETFEAT) featRd_q <= 32'h00000000;
            state_q <= ST_DONE;
          end else if (op_q != `OP_DIESTAT && step_q == 4'd0 &&
                       !nandRbN) begin
            // Hold the first byte back until every die is ready
            state_q <= ST_SETUP;
          end else begin
            nandCeN <= 1'b0;
            nandCle <= (kindNow == K_CMD);
            nandAle <= (kindNow == K_ADR);
            nandIoOut <= byteVal(op_q, step_q, arg0_q, arg1_q, featDrive_q);
            nandIoOe <= (kindNow != K_RD);
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (kindNow == K_RD) nandReN <= 1'b0;
          else nandWeN <= 1'b0;
          if (tDone) begin
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          nandWeN <= 1'b1;
          nandReN <= 1'b1;
          // every parameter byte of a read collected
          if (kindNow == K_RD && !nandReN) begin
            if (op_q == `OP_GETFEAT) begin
              featRd_q <= {nandIoIn, featRd_q[31:8]};
            end else begin
              // die status byte carries protection on bit 7
              dieStat_q <= nandIoIn;
            end
          end
          if (tDone) begin
            nandCle <= 1'b0;
            nandAle <= 1'b0;
            if (waitsBusy) begin
              state_q <= ST_WAIT;
            end else if (!lastStep) begin
              step_q <= step_q + 4'h1;
              state_q <= ST_SETUP;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          nandIoOe <= 1'b0;
          // wait for the open-drain line to come back high
          if (tDone && nandRbN) begin
            if (lastStep) begin
              state_q <= ST_DONE;
            end else begin
              step_q <= step_q + 4'h1;
              state_q <= ST_SETUP;
            end
          end
        end
        ST_DONE: begin
          nandCeN <= 1'b1;
          nandIoOe <= 1'b0;
          busy_q <= 1'b0;
          state_q <= ST_IDLE;
          // failure of protected op read later through 78h
          lastInfo_q <= (op_q == `OP_RESET) || (op_q == `OP_SETFEAT) ||
                        (op_q == `OP_GETFEAT);
          if (op_q == `OP_DIESTAT) begin
            protFail_q <= !dieStat_q[`STS_PROT_N];
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // nand_feature_protect_die_ctrl
`default_nettype wire

//--- nand_host_map.vh
// Constants for the NAND feature, protection and die host controller
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH
// Register offsets of the host's own registers (byte addresses)
`define REG_CTRL 8'h00
`define REG_ARG0 8'h04
`define REG_ARG1 8'h08
`define REG_STAT 8'h0C
`define REG_FEAT 8'h10
`define REG_DSTAT 8'h14
// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 4
`define CTRL_OP_MSB 7
`define CTRL_WP_BIT 8
// Operation codes written to the control register
`define OP_SETFEAT 4'h1
`define OP_GETFEAT 4'h2
`define OP_PROTECT 4'h3
`define OP_DIESTAT 4'h4
`define OP_RESET 4'h5
`define OP_PROGRAM 4'h6
`define OP_ERASE 4'h7
// Device command bytes
`define CMD_SETFEAT 8'hEF
`define CMD_GETFEAT 8'hEE
`define CMD_PROT0 8'h4C
`define CMD_PROT1 8'h03
`define CMD_PROT2 8'h1D
`define CMD_PROT3 8'h42
`define CMD_DIESTAT 8'h78
`define CMD_RESET 8'hFF
`define CMD_PROG0 8'h80
`define CMD_PROG1 8'h10
`define CMD_ERASE0 8'h60
`define CMD_ERASE1 8'hD0
// Feature address and reset value
`define FEAT_DRIVE_ADDR 8'h10
`define FEAT_DRIVE_RST 8'h00
// Status bit positions
`define STS_ARRAY_RDY 5
`define STS_PROT_N 7
// Timing: strobe phases in ns and cycles at 50 ns
`define CLK_NS 50
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define FEAT_NS 1000
`define FEAT_CYC ((`FEAT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- strobe_timer.v
// Down counter that times one bus phase
`timescale 1ns/1ps
`default_nettype none
module strobe_timer (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  // Control
  input wire load,
  input wire [7:0] count,
  output wire done
);
  reg [7:0] cnt_q;
  // Count down while enabled; reload on request
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
    end else if (clkEn) begin
      if (load) begin
        cnt_q <= count;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // Bare zero count: gating it with load would close a loop through the
  // caller, whose load decision itself looks at done
  assign done = (cnt_q == 8'h00);
endmodule // strobe_timer
`default_nettype wire

//--- page_order_check.v
// Tracks the next page that may be programmed in one block
`timescale 1ns/1ps
`default_nettype none
module page_order_check (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  // Request
  input wire [15:0] blockAddr,
  input wire [5:0] pageAddr,
  input wire commit,
  input wire eraseDone,
  output wire inOrder
);
  reg [15:0] lastBlock_q;
  reg [5:0] nextPage_q;
  // A new block must start at page 0; same block must be next page
  assign inOrder = (blockAddr == lastBlock_q) ? (pageAddr == nextPage_q)
                                              : (pageAddr == 6'h00);
  // Remember the most recent program position
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lastBlock_q <= 16'hFFFF;
      nextPage_q <= 6'h00;
    end else if (clkEn) begin
      if (commit) begin
        lastBlock_q <= blockAddr;
        nextPage_q <= pageAddr + 6'h01;
      end else if (eraseDone && blockAddr == lastBlock_q) begin
        nextPage_q <= 6'h00;
      end
    end
  end
endmodule // page_order_check
`default_nettype wire

//--- nand_ctrl_properties.sv
// Checker on the NAND pins driven by the host controller
`timescale 1ns/1ps
`default_nettype none
module nand_ctrl_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // NAND pins
  input wire logic nandCeN,
  input wire logic nandCle,
  input wire logic nandAle,
  input wire logic nandWeN,
  input wire logic nandReN,
  input wire logic [7:0] nandIoOut,
  input wire logic nandIoOe,
  input wire logic nandRbN
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic weLow_q, reLow_q, cle_q, ale_q, featOpen_q;
  logic [7:0] byte_q, lastCmd_q;
  logic [3:0] nAddr_q, nData_q, nRead_q;
  wire weRise = nandWeN && weLow_q;
  wire cmdLat = weRise && cle_q;
  wire reRise = nandReN && reLow_q;
  // Bytes are captured while the strobe is low, counted at its rise
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {weLow_q, reLow_q, cle_q, ale_q, featOpen_q} <= 5'h0;
      {byte_q, lastCmd_q} <= 16'h0;
      {nAddr_q, nData_q, nRead_q} <= 12'h0;
    end else begin
      weLow_q <= !nandWeN;
      reLow_q <= !nandReN;
      if (!nandWeN) begin
        byte_q <= nandIoOut;
        cle_q <= nandCle;
        ale_q <= nandAle;
      end
      if (cmdLat) begin
        lastCmd_q <= byte_q;
        {nAddr_q, nData_q, nRead_q} <= 12'h0;
      end else begin
        nAddr_q <= nAddr_q + {3'h0, weRise && ale_q};
        nData_q <= nData_q + {3'h0, weRise && !ale_q};
        nRead_q <= nRead_q + {3'h0, reRise};
      end
      // A feature sequence stays open until the chip is deselected
      if (cmdLat && (byte_q == 8'hEF || byte_q == 8'hEE))
        featOpen_q <= 1'b1;
      else if (nandCeN)
        featOpen_q <= 1'b0;
    end
  end
  a_feat_write_len: assert property (cmdLat && lastCmd_q == 8'hEF |->
    nAddr_q == 4'h1 && nData_q == 4'h4) else $error("feature write length");
  a_feat_read_len: assert property (cmdLat && lastCmd_q == 8'hEE |->
    nRead_q == 4'h4) else $error("feature read cut short");
  a_feat_no_intrude: assert property (cmdLat &&
    (byte_q == 8'hFF || byte_q == 8'h78) |-> !featOpen_q)
    else $error("reset or 78h inside feature");
  a_status_row_len: assert property (reRise && lastCmd_q == 8'h78 |->
    nAddr_q == 4'h3) else $error("die status row count");
  a_no_plain_status: assert property (cmdLat |-> byte_q != 8'h70)
    else $error("plain status command issued");
  a_prot_cmd_order: assert property (cmdLat && byte_q == 8'h42 |->
    lastCmd_q == 8'h1D) else $error("protect sequence out of order");
  a_array_when_ready: assert property (cmdLat &&
    (byte_q == 8'h80 || byte_q == 8'h60) |-> nandRbN)
    else $error("array op while busy");
  a_we_pulse_shape: assert property ($fell(nandWeN) |-> nandIoOe ##1
    !nandWeN ##1 !nandWeN ##1 nandWeN) else $error("write strobe width wrong");
endmodule // nand_ctrl_checker
bind nand_feature_protect_die_ctrl nand_ctrl_checker chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .nandCeN(nandCeN), .nandCle(nandCle),
  .nandAle(nandAle), .nandWeN(nandWeN), .nandReN(nandReN),
  .nandIoOut(nandIoOut), .nandIoOe(nandIoOe), .nandRbN(nandRbN));
`default_nettype wire

//--- nand_die_model.sv
// Behavioural NAND device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nand_die_model #(
  parameter integer featNs = 1000,
  parameter integer arrayNs = 3000,
  parameter integer protNs = 2000
) (
  // Host-driven pins
  input wire logic ceN,
  input wire logic cle,
  input wire logic ale,
  input wire logic weN,
  input wire logic reN,
  input wire logic wpN,
  input wire logic [7:0] ioIn,
  // Device-driven pins
  output logic [7:0] ioOut,
  output logic rbN
);
  logic [7:0] cmd, drive, range_invert_sel, p0;
  logic [7:0] ab [0:4];
  logic [15:0] hiBlk;
  logic prot;
  integer nA, nD, nR, stage;
  realtime busyEnd;
  function automatic logic hit(input integer i);
    logic [23:0] r;
    r = {ab[i + 2], ab[i + 1], ab[i]};
    hit = prot && (range_invert_sel == 8'hFF ? r[21:6] > hiBlk : r[21:6] <= hiBlk);
  endfunction
  task automatic goBusy(input integer ns);
    rbN = 1'b0;
    busyEnd = $realtime + ns;
  endtask
  initial begin
    {rbN, prot, drive, range_invert_sel, cmd, p0, hiBlk} = {2'b10, 48'h0};
    {nA, nD, nR, stage} = 128'h0;
    ioOut = 8'hA5;
    busyEnd = 0;
  end
  // open drain released when the work ends
  always #10 if (!rbN && $realtime >= busyEnd) rbN = 1'b1;
  // Bytes are taken on the rising write strobe
  always @(posedge weN) begin
    if (!ceN && cle) begin
      // protected target stays busy, then abandons
      if (ioIn == 8'h10 || ioIn == 8'hD0)
        goBusy(hit(ioIn == 8'h10 ? 2 : 0) ? protNs : arrayNs);
      else if (cmd == 8'h4C && (ioIn == 8'h03 || ioIn == 8'h1D || ioIn == 8'h42))
        stage = stage + 1;
      else begin
        cmd = ioIn;
        {nA, nD, nR, stage} = 128'h0;
        // reset leaves the drive setting alone
        if (ioIn == 8'hFF) goBusy(featNs);
      end
    end else if (!ceN && ale && nA < 5) begin
      // row bytes kept for status and array commands
      ab[nA] = ioIn;
      nA = nA + 1;
      if (cmd == 8'hEE) goBusy(featNs);
    end else if (!ceN && cmd == 8'hEF) begin
      // only address 10h takes the first parameter
      if (nD == 0) p0 = ioIn;
      nD = nD + 1;
      if (nD == 4 && ab[0] == 8'h10) drive = p0;
      if (nD == 4) goBusy(featNs);
    end
    // range locked once, high block MSB first
    if (cmd == 8'h4C && stage == 3 && nA == 5 && !prot) begin
      prot = 1'b1;
      hiBlk = {ab[2], ab[3]};
      range_invert_sel = ab[4];
    end
  end
  // answer on the falling read strobe
  always @(negedge reN) begin
    if (!ceN && cmd == 8'hEE)
      ioOut = (nR == 0 && ab[0] == 8'h10) ? drive : 8'h00;
    else if (!ceN)
      ioOut = {!hit(0) && wpN, rbN, rbN, 5'h00};
    nR = nR + 1;
  end
  // Released bus shows the inverse, so a stale byte never reads right
  always @(posedge reN) ioOut = ~ioOut;
endmodule // nand_die_model
`default_nettype wire

//--- nand_feature_protect_die_ctrl_tb.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.vh"
module nand_feature_protect_die_ctrl_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, ceN, cle, ale, weN, reN, wpN, ioOe, rbN;
  logic [7:0] ioOut, ioIn;
  integer nMismatch = 0, nTests = 0, i;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  nand_feature_protect_die_ctrl dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nandCeN(ceN), .nandCle(cle),
    .nandAle(ale), .nandWeN(weN), .nandReN(reN), .nandWpN(wpN),
    .nandIoOut(ioOut), .nandIoOe(ioOe), .nandIoIn(ioIn), .nandRbN(rbN));
  nand_die_model dev (
    .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN), .wpN(wpN),
    .ioIn(ioOut), .ioOut(ioIn), .rbN(rbN));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests = nTests + 1;
    if (seen !== exp) begin
      nMismatch = nMismatch + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("tests=%0d mismatches=%0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Single AHB-Lite word; both phases wait on hready, read taken last
  task automatic xfer(input logic [7:0] a, input logic wr,
      input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  // Start an operation with write protect released, poll until idle
  task automatic runOp(input logic [3:0] op, input logic [31:0] a0, a1);
    integer k;
    xfer(`REG_ARG0, 1'b1, a0);
    xfer(`REG_ARG1, 1'b1, a1);
    xfer(`REG_CTRL, 1'b1, {23'h0, 1'b1, op, 3'h0, 1'b1});
    k = 0;
    rd = 32'h1;
    while (rd[0] === 1'b1 && k < 400) begin
      xfer(`REG_STAT, 1'b0, 32'h0);
      k = k + 1;
    end
    chk(rd[0], 1'b0);
  endtask
  // Read feature bytes of one address
  task automatic featChk(input logic [7:0] fa, input logic [31:0] exp);
    runOp(`OP_GETFEAT, {24'h0, fa}, 32'h0);
    xfer(`REG_FEAT, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Per-die status of one block, page 0, die 0
  task automatic dieChk(input logic [15:0] blk, input logic [7:0] exp);
    runOp(`OP_DIESTAT, {10'h0, blk, 6'h0}, 32'h0);
    chk(rd[4], !exp[7]);
    xfer(`REG_DSTAT, 1'b0, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk(wpN, 1'b0);
    xfer(`REG_STAT, 1'b0, 32'h0);
    chk(rd[1:0], 2'b10);
    xfer(8'h3C, 1'b0, 32'h0);
    chk(rd, 32'h0);
    featChk(8'h10, 32'h0);
    // drive codes 0 to 3 written and read back
    for (i = 0; i < 4; i = i + 1) begin
      runOp(`OP_SETFEAT, 32'h10, i ^ 1);
      chk(rd[5], 1'b1);
      featChk(8'h10, i ^ 1);
    end
    // Reserved address leaves the setting, reads zero
    runOp(`OP_SETFEAT, 32'h11, 32'h3);
    featChk(8'h11, 32'h0);
    featChk(8'h10, 32'h2);
    runOp(`OP_RESET, 32'h0, 32'h0);
    featChk(8'h10, 32'h2);
    runOp(`OP_PROGRAM, 32'h240, 32'h0);
    chk(rd[3], 1'b1);
    // Protect blocks 0..5, then a second setup must not take
    runOp(`OP_PROTECT, 32'h0, 32'h0000_0005);
    dieChk(16'd3, 8'h60);
    dieChk(16'd9, 8'hE0);
    runOp(`OP_PROTECT, 32'h0, 32'h00FF_0010);
    dieChk(16'd3, 8'h60);
    runOp(`OP_PROGRAM, 32'hC0, 32'h0);
    dieChk(16'd3, 8'h60);
    // Pages of block 9 in order, then one skipped
    runOp(`OP_PROGRAM, 32'h240, 32'h0);
    runOp(`OP_PROGRAM, 32'h241, 32'h0);
    chk(rd[2], 1'b0);
    runOp(`OP_PROGRAM, 32'h243, 32'h0);
    chk(rd[2], 1'b1);
    // Erase reopens block 9 at its first page
    runOp(`OP_ERASE, 32'h240, 32'h0);
    runOp(`OP_PROGRAM, 32'h240, 32'h0);
    chk(rd[2], 1'b0);
    tally_and_finish;
  end
  // Watchdog far past the expected run length
  initial begin
    #3000000;
    nMismatch = nMismatch + 1;
    tally_and_finish;
  end
endmodule // nand_feature_protect_die_ctrl_tb
`default_nettype wire
